//--- dv/power_button_wake_controller_tb.sv
// Self-checking bench for the power button and wake controller.
// Assumes short hold and debounce counts set by parameter for a fast run.
`timescale 1ns/10ps
`default_nettype none
module power_button_wake_controller_tb;
  import pwr_wake_pkg::*;
  typedef struct packed {logic [2:0] tgt; logic fast; logic perm; logic fw; logic [2:0] src; logic wake;} row_t;
  // Targets: 0 S3, 1 S4, 2 S5, 3 deep S4, 4 deep S5; sources: rtc, net, usb, pcie, infrared, radio
  localparam row_t ROWS [25] = '{'{0,0,0,0,0,1}, '{1,0,0,0,0,1}, '{2,0,0,0,0,1},
    '{1,0,0,0,1,1}, '{2,0,0,0,1,1}, '{2,1,0,0,1,0},
    '{0,0,0,0,2,1}, '{1,0,0,1,2,0}, '{1,0,1,1,2,1}, '{1,0,1,0,2,0}, '{2,0,0,0,2,0},
    '{2,0,0,1,2,1}, '{3,0,1,1,2,0}, '{2,1,0,1,2,0},
    '{0,0,0,0,3,1}, '{1,0,0,0,3,1}, '{2,0,0,0,3,0}, '{4,0,0,0,3,0},
    '{0,0,0,0,4,1}, '{2,0,0,0,4,1}, '{3,0,0,0,4,0}, '{4,0,0,0,4,0}, '{2,1,0,0,4,0},
    '{0,0,0,0,5,0}, '{2,0,0,0,5,0}};
  localparam sys_state_t TGT [5] = '{SYS_S3, SYS_S4, SYS_S5, SYS_DEEP_S4, SYS_DEEP_S5};
  logic       clk, rstn, press, mains_restored, os_sleep_req, os_sleep_hibernate, os_sleep_off;
  logic       os_short_press_off, os_deep_sleep, os_fast_startup, os_usb_s4_permit, fw_usb_s45_wake_en;
  logic       pwr_switch_n, rtc_alarm, network_wake, usb_wake, pcie_wake_n, infrared_remote_wake, radio_wake;
  logic       sys_working, forced_off, wake_event;
  logic [5:0] src_req, wake_cause;
  sys_state_t sys_state;
  int         checks, error_cnt, we_cnt, fo_cnt;
  wake_source_model u_wake_source_model (.press, .src_req, .pwr_switch_n, .rtc_alarm, .network_wake,
    .usb_wake, .pcie_wake_n, .infrared_remote_wake, .radio_wake);
  power_button_wake_controller #(.SHORT_CYC(133), .LONG_CYC(200), .DEB_CYC(4)) u_power_button_wake_controller (
    .clk, .rstn,
    .pwr_switch_n, .rtc_alarm, .network_wake, .usb_wake, .pcie_wake_n, .infrared_remote_wake, .radio_wake,
    .os_sleep_req, .os_sleep_hibernate, .os_sleep_off, .os_short_press_off, .os_deep_sleep, .os_fast_startup,
    .os_usb_s4_permit, .fw_usb_s45_wake_en, .mains_restored, .sys_state, .sys_working, .forced_off,
    .wake_event, .wake_cause);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pulses are counted on the falling edge so reads never race the launching edge
  always @(negedge clk) begin
    if (wake_event === 1'b1) we_cnt++;
    if (forced_off === 1'b1) fo_cnt++;
  end
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Hold counts from the debounced edge, so 40 idle cycles cover release filtering
  task automatic push(input int n);
    press <= 1'b1;
    cyc(n);
    press <= 1'b0;
    cyc(40);
  endtask
  task automatic go_sleep(input logic [2:0] t);
    os_sleep_hibernate <= t == 1 || t == 3;
    os_sleep_off       <= t == 2 || t == 4;
    os_deep_sleep      <= t > 2;
    os_sleep_req       <= 1'b1;
    for (int i = 0; i < 20 && sys_working !== 1'b0; i++) cyc(1);
    os_sleep_req <= 1'b0;
    cyc(4);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    row_t r;
    int   n;
    {rstn, press, mains_restored, src_req, os_sleep_req, os_sleep_hibernate, os_sleep_off} = '0;
    {os_short_press_off, os_deep_sleep, os_fast_startup, os_usb_s4_permit, fw_usb_s45_wake_en} = '0;
    cyc(6);
    chk(sys_state, SYS_S5);
    chk({sys_working, forced_off, wake_event, 3'h0}, 6'h00);
    rstn <= 1'b1;
    cyc(2);
    push(20);
    chk(sys_state, SYS_S0);
    chk(6'(we_cnt), 6'h01);
    $display("reset and power on done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      if (sys_working !== 1'b1) push(20);
      os_fast_startup    <= r.fast;
      os_usb_s4_permit   <= r.perm;
      fw_usb_s45_wake_en <= r.fw;
      go_sleep(r.tgt);
      chk(sys_state, TGT[r.tgt]);
      n = we_cnt;
      src_req[r.src] <= 1'b1;
      cyc(30);
      chk(6'(we_cnt - n), 6'(r.wake));
      chk(sys_state, r.wake ? SYS_S0 : TGT[r.tgt]);
      if (r.wake) chk(wake_cause, 6'h01 << r.src);
      src_req <= 6'h00;
      cyc(10);
      $display("row %0d done", i);
    end
    if (sys_working !== 1'b1) push(20);
    os_deep_sleep <= 1'b0;
    push(20);
    chk(sys_state, SYS_S3);
    push(20);
    os_short_press_off <= 1'b1;
    n = fo_cnt;
    push(150);
    chk(sys_state, SYS_S5);
    chk(6'(fo_cnt - n), 6'h00);
    $display("short press tests done");
    push(20);
    push(260);
    chk(sys_state, SYS_S5);
    os_short_press_off <= 1'b0;
    push(20);
    go_sleep(0);
    push(260);
    chk(sys_state, SYS_S5);
    push(260);
    chk(6'(fo_cnt - n), 6'h02);
    $display("long press tests done");
    fw_usb_s45_wake_en <= 1'b1;
    os_fast_startup    <= 1'b0;
    mains_restored     <= 1'b1;
    cyc(2);
    mains_restored <= 1'b0;
    n = we_cnt;
    src_req <= 6'h04;
    cyc(30);
    chk(6'(we_cnt - n), 6'h00);
    src_req <= 6'h02;
    cyc(30);
    chk(6'(we_cnt - n), 6'h01);
    chk(wake_cause, 6'h02);
    $display("mains loss test done");
    rstn    <= 1'b0;
    src_req <= 6'h00;
    cyc(2);
    chk(sys_state, SYS_S5);
    chk(wake_cause, 6'h00);
    chk({sys_working, forced_off, wake_event, 3'h0}, 6'h00);
    rstn <= 1'b1;
    cyc(2);
    n = we_cnt;
    push(20);
    chk(sys_state, SYS_S0);
    chk(6'(we_cnt - n), 6'h01);
    chk(wake_cause, 6'h00);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule // power_button_wake_controller_tb
`default_nettype wire

//--- dv/wake_ctrl_checker_sva.sv
// Port checker for the power button and wake controller.
// Assumes it is bound to the controller top; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module wake_ctrl_checker (
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic                     os_fast_startup,
  input wire logic                     os_usb_s4_permit,
  input wire logic                     fw_usb_s45_wake_en,
  input wire pwr_wake_pkg::sys_state_t sys_state,
  input wire logic                     sys_working,
  input wire logic                     forced_off,
  input wire logic                     wake_event,
  input wire logic [5:0]               wake_cause
);
  import pwr_wake_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_wake_to_work: assert property (wake_event |-> sys_state == SYS_S0 && sys_working)
    else $error("wake pulse outside working");
  a_rise_has_wake: assert property ($rose(sys_working) |-> wake_event && $past(sys_state) != SYS_S0)
    else $error("working entered without wake pulse");
  a_force_to_off: assert property (forced_off |-> ##[0:1] sys_state == SYS_S5 && !sys_working)
    else $error("forced off did not reach soft off");
  a_force_single: assert property (forced_off |=> !forced_off)
    else $error("forced off pulse too long");
  a_radio_never: assert property (wake_event |-> !wake_cause[5])
    else $error("radio wake cause");
  a_pcie_not_off: assert property (wake_event && wake_cause[3] |->
    !($past(sys_state) inside {SYS_S5, SYS_DEEP_S5}))
    else $error("pcie wake from soft off");
  a_usb_wake_gate: assert property (wake_event && wake_cause[2] |-> $past(sys_state) == SYS_S3 ||
    $past(fw_usb_s45_wake_en) && ($past(sys_state) == SYS_S5 ||
    $past(sys_state) == SYS_S4 && $past(os_usb_s4_permit)))
    else $error("usb wake not permitted");
  a_ir_not_deep: assert property (wake_event && wake_cause[4] |->
    !($past(sys_state) inside {SYS_DEEP_S4, SYS_DEEP_S5}))
    else $error("infrared wake from deep state");
  a_fast_start_block: assert property (wake_event && (wake_cause[1] || wake_cause[2] || wake_cause[4]) &&
    $past(sys_state) inside {SYS_S5, SYS_DEEP_S5} |-> !$past(os_fast_startup))
    else $error("wake from soft off under fast startup");
endmodule // wake_ctrl_checker
bind power_button_wake_controller wake_ctrl_checker u_wake_ctrl_checker (.clk(clk), .rstn(rstn),
  .os_fast_startup(os_fast_startup), .os_usb_s4_permit(os_usb_s4_permit),
  .fw_usb_s45_wake_en(fw_usb_s45_wake_en), .sys_state(sys_state), .sys_working(sys_working),
  .forced_off(forced_off), .wake_event(wake_event), .wake_cause(wake_cause));
`default_nettype wire

//--- dv/wake_source_model.sv
// Front panel and wake source model: bench requests become pin levels.
// Assumes requests change just after a clock edge; pins are plain levels.
`timescale 1ns/10ps
`default_nettype none
module wake_source_model (
  input  wire logic       press,
  input  wire logic [5:0] src_req,
  output logic            pwr_switch_n,
  output logic            rtc_alarm,
  output logic            network_wake,
  output logic            usb_wake,
  output logic            pcie_wake_n,
  output logic            infrared_remote_wake,
  output logic            radio_wake
);
  assign pwr_switch_n         = ~press;      // Low while held
  assign rtc_alarm            = src_req[0];
  assign network_wake         = src_req[1];
  assign usb_wake             = src_req[2];
  assign pcie_wake_n          = ~src_req[3]; // Active low on the bus
  assign infrared_remote_wake = src_req[4];
  assign radio_wake           = src_req[5];
endmodule // wake_source_model
`default_nettype wire

//--- include/pwr_wake_defs.svh
// Timing counts and state encodings for the power button and wake controller.
// Assumes a single 200 MHz clock; included by the package and the controller top.
// Behaviour
// - Off or sleeping, press under four seconds brings the system to working.
// - Working or sleeping, press held past six seconds forces soft-off.
// - Short press while working sleeps or powers off per OS setting.
// - RTC alarm wakes from S3, S4 and S5; monitoring continues while asleep.
// - Network wake works from S3, S4, S5, and from S5 after mains loss.
// - USB wakes from S3; S4/S5 only by firmware option, never after mains loss.
// - USB S4 wake also needs OS driver permission; never from deep S4/S5.
// - PCIe wake signal wakes from S3 or S4 only, ignored in S5.
// - Infrared remote wakes from S3, S4, S5 except deep S4 or deep S5.
// - The short-range radio module never wakes the system.
// - Fast startup blocks network, USB and infrared wake from S5.
`ifndef PWR_WAKE_DEFS_SVH
`define PWR_WAKE_DEFS_SVH

`define CLK_MHZ            200
`define SHORT_PRESS_MS     4000
`define LONG_PRESS_MS      6000
`define MS_CYCLES(ms)      ((ms) * 1000 * `CLK_MHZ)
`define SHORT_PRESS_CYC    `MS_CYCLES(`SHORT_PRESS_MS)
`define LONG_PRESS_CYC     `MS_CYCLES(`LONG_PRESS_MS)
`define DEBOUNCE_CYC       16

`define ST_S0              6'h01
`define ST_S3              6'h02
`define ST_S4              6'h04
`define ST_S5              6'h08
`define ST_DEEP_S4         6'h10
`define ST_DEEP_S5         6'h20

`endif

//--- include/pwr_wake_pkg.sv
// Types for the power button and wake controller.
// Assumes the defs header is on the include path.
`include "pwr_wake_defs.svh"
package pwr_wake_pkg;
  typedef enum logic [5:0] {
    SYS_S0      = `ST_S0,
    SYS_S3      = `ST_S3,
    SYS_S4      = `ST_S4,
    SYS_S5      = `ST_S5,
    SYS_DEEP_S4 = `ST_DEEP_S4,
    SYS_DEEP_S5 = `ST_DEEP_S5
  } sys_state_t;
endpackage

//--- rtl/input_sync.sv
// Three-stage synchroniser bank with agreement filter for pin inputs.
// Assumes asynchronous pins; output changes only when stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Hold the last agreed value while stages two and three disagree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          sync_out[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule // input_sync
`default_nettype wire

//--- rtl/power_button_wake_controller.sv
// Power-state controller: power switch press timing and wake source qualification.
// Assumes pins are asynchronous to clk and config bits come from firmware/OS latches.
`timescale 1ns/10ps
`default_nettype none
`include "pwr_wake_defs.svh"
module power_button_wake_controller #(
  parameter int unsigned SHORT_CYC = `SHORT_PRESS_CYC,
  parameter int unsigned LONG_CYC  = `LONG_PRESS_CYC,
  parameter int unsigned DEB_CYC   = `DEBOUNCE_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     pwr_switch_n,
  input  wire logic                     rtc_alarm,
  input  wire logic                     network_wake,
  input  wire logic                     usb_wake,
  input  wire logic                     pcie_wake_n,
  input  wire logic                     infrared_remote_wake,
  input  wire logic                     radio_wake,
  input  wire logic                     os_sleep_req,
  input  wire logic                     os_sleep_hibernate,
  input  wire logic                     os_sleep_off,
  input  wire logic                     os_short_press_off,
  input  wire logic                     os_deep_sleep,
  input  wire logic                     os_fast_startup,
  input  wire logic                     os_usb_s4_permit,
  input  wire logic                     fw_usb_s45_wake_en,
  input  wire logic                     mains_restored,
  output pwr_wake_pkg::sys_state_t      sys_state,
  output logic                          sys_working,
  output logic                          forced_off,
  output logic                          wake_event,
  output logic [5:0]                    wake_cause
);
  import pwr_wake_pkg::*;

  typedef enum logic [2:0] {
    BTN_IDLE  = 3'h1,
    BTN_SHORT = 3'h2,
    BTN_LONG  = 3'h4
  } btn_state_t;

  localparam int CNT_W = $clog2(LONG_CYC + 2);

  logic [6:0]       pin_sync;
  logic             btn_raw;
  logic             btn_level_ff;
  logic [7:0]       deb_cnt_ff;
  logic             btn_prev_ff;
  btn_state_t       btn_ff;
  btn_state_t       nxt_btn;
  logic [CNT_W-1:0] hold_cnt_ff;
  logic             short_rel;
  logic             long_hit;
  logic             after_g3_ff;
  sys_state_t       state_ff;
  sys_state_t       nxt_state;
  logic [5:0]       cause;
  logic             any_wake;
  logic             deb_done;
  logic             press_edge;
  logic [5:0]       wake_src;
  logic             waking;

  input_sync #(.W(7)) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .pin_in   ({radio_wake, ~pcie_wake_n, infrared_remote_wake, usb_wake,
                network_wake, rtc_alarm, ~pwr_switch_n}),
    .sync_out (pin_sync)
  );

  assign btn_raw  = pin_sync[0];
  assign deb_done = (btn_raw != btn_level_ff) && (deb_cnt_ff >= 8'(DEB_CYC - 1));

  // Debounce: a switch level counts only after it has held steady
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deb_cnt_ff <= 8'h00;
    end else if ((btn_raw == btn_level_ff) || deb_done) begin
      deb_cnt_ff <= 8'h00;
    end else begin
      deb_cnt_ff <= deb_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      btn_level_ff <= 1'b0;
    end else if (deb_done) begin
      btn_level_ff <= btn_raw;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      btn_prev_ff <= 1'b0;
    end else begin
      btn_prev_ff <= btn_level_ff;
    end
  end

  // Edge from the debounced level, so contact bounce cannot start a second press
  assign press_edge = btn_level_ff && !btn_prev_ff;

  // Hold counter saturates so a stuck switch cannot wrap into a short press
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt_ff <= '0;
    end else if (!btn_level_ff) begin
      hold_cnt_ff <= '0;
    end else if (hold_cnt_ff <= CNT_W'(LONG_CYC)) begin
      hold_cnt_ff <= hold_cnt_ff + 1'b1;
    end
  end

  always_comb begin
    nxt_btn = btn_ff;
    case (btn_ff)
      BTN_IDLE: begin
        if (press_edge) begin
          nxt_btn = BTN_SHORT;
        end
      end
      BTN_SHORT: begin
        if (!btn_level_ff) begin
          nxt_btn = BTN_IDLE;
        end else if (hold_cnt_ff > CNT_W'(LONG_CYC)) begin
          nxt_btn = BTN_LONG;
        end
      end
      BTN_LONG: begin
        if (!btn_level_ff) begin
          nxt_btn = BTN_IDLE;
        end
      end
      default: nxt_btn = BTN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      btn_ff <= BTN_IDLE;
    end else begin
      btn_ff <= nxt_btn;
    end
  end

  // Release after less than six seconds is a short press, 4..6 s included
  assign short_rel = (btn_ff == BTN_SHORT) && !btn_level_ff;
  assign long_hit  = (btn_ff == BTN_SHORT) && (hold_cnt_ff > CNT_W'(LONG_CYC));

  // Mains loss marker; cleared once the system reaches working again
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      after_g3_ff <= 1'b0;
    end else if (mains_restored) begin
      after_g3_ff <= 1'b1;
    end else if (state_ff == SYS_S0) begin
      after_g3_ff <= 1'b0;
    end
  end

  function automatic logic is_s5(input sys_state_t s);
    return (s == SYS_S5) || (s == SYS_DEEP_S5);
  endfunction

  function automatic logic is_asleep(input sys_state_t s);
    return s != SYS_S0;
  endfunction

  function automatic sys_state_t off_target(input logic deep);
    return deep ? SYS_DEEP_S5 : SYS_S5;
  endfunction

  // Allowed sources per state, bits in wake_cause order; the radio bit never qualifies
  function automatic logic [5:0] wake_mask(input sys_state_t s,
                                           input logic       fast,
                                           input logic       usb_s4,
                                           input logic       usb_s5);
    logic [5:0] m;
    m = 6'h00;
    case (s)
      SYS_S3: begin
        m = 6'h1f;
      end
      SYS_S4: begin
        m = {3'b011, usb_s4, 2'b11};
      end
      SYS_DEEP_S4: begin
        m = 6'h0b;
      end
      SYS_S5: begin
        m = {1'b0, !fast, 1'b0, usb_s5 && !fast, !fast, 1'b1};
      end
      SYS_DEEP_S5: begin
        m = {4'h0, !fast, 1'b1};
      end
      default: begin
        m = 6'h00;
      end
    endcase
    return m;
  endfunction

  // Sources are watched continuously while asleep, gathered in wake_cause bit order
  assign wake_src = {pin_sync[6], pin_sync[4], pin_sync[5], pin_sync[3], pin_sync[2], pin_sync[1]};

  // USB from S4/S5 needs the firmware option and is lost after mains loss
  always_comb begin
    cause    = wake_src & wake_mask(state_ff, os_fast_startup,
                                    fw_usb_s45_wake_en && os_usb_s4_permit && !after_g3_ff,
                                    fw_usb_s45_wake_en && !after_g3_ff);
    any_wake = |cause;
  end

  assign waking = is_asleep(state_ff) && (nxt_state == SYS_S0);

  // Long press outranks release and wake in S0, S3, S4 and deep S4; in S5 or deep S5 a wake still brings the system to working
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SYS_S0: begin
        if (long_hit) begin
          nxt_state = SYS_S5;
        end else if (short_rel) begin
          nxt_state = os_short_press_off ? off_target(os_deep_sleep) : SYS_S3;
        end else if (os_sleep_req) begin
          if (os_sleep_off) begin
            nxt_state = off_target(os_deep_sleep);
          end else if (os_sleep_hibernate) begin
            nxt_state = os_deep_sleep ? SYS_DEEP_S4 : SYS_S4;
          end else begin
            nxt_state = SYS_S3;
          end
        end
      end
      SYS_S3, SYS_S4, SYS_DEEP_S4: begin
        if (long_hit) begin
          nxt_state = SYS_S5;
        end else if (short_rel || any_wake) begin
          nxt_state = SYS_S0;
        end
      end
      SYS_S5, SYS_DEEP_S5: begin
        if (short_rel || any_wake) begin
          nxt_state = SYS_S0;
        end
      end
      default: nxt_state = SYS_S5;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= SYS_S5;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from flops; sys_state tracks state_ff cycle for cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_state <= SYS_S5;
    end else begin
      sys_state <= nxt_state;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_working <= 1'b0;
    end else begin
      sys_working <= (nxt_state == SYS_S0);
    end
  end

  // No pulse when already off: a long press in soft-off changes nothing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      forced_off <= 1'b0;
    end else begin
      forced_off <= long_hit && !is_s5(state_ff);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= waking;
    end
  end

  // Cause stays until the next wake; zero when only the switch woke the system
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_cause <= 6'h00;
    end else if (waking) begin
      wake_cause <= cause;
    end
  end
endmodule // power_button_wake_controller
`default_nettype wire
